/* ctu_pkg.sv */
`default_nettype none
package ctu_pkg;
  // register index per register; the bus byte address is the index times four
  localparam logic [11:0] CTU_IDX_CURRENT_CONTROL   = 12'hfb1;
  localparam logic [11:0] CTU_IDX_EDGE_CONTROL_LOW  = 12'hfb2;
  localparam logic [11:0] CTU_IDX_UNIT_CONTROL_HIGH = 12'hfb3;
  localparam logic [11:0] CTU_IDX_IRQ_STATUS        = 12'hfb4;
  localparam logic [11:0] CTU_IDX_IRQ_MASK          = 12'hfb5;
  localparam int          CTU_ADDR_W                = 14;
  localparam logic [13:0] CTU_ADR_CURRENT    = {CTU_IDX_CURRENT_CONTROL, 2'b00};
  localparam logic [13:0] CTU_ADR_EDGE_LOW   = {CTU_IDX_EDGE_CONTROL_LOW, 2'b00};
  localparam logic [13:0] CTU_ADR_UNIT_HIGH  = {CTU_IDX_UNIT_CONTROL_HIGH, 2'b00};
  localparam logic [13:0] CTU_ADR_IRQ_STATUS = {CTU_IDX_IRQ_STATUS, 2'b00};
  localparam logic [13:0] CTU_ADR_IRQ_MASK   = {CTU_IDX_IRQ_MASK, 2'b00};
  // unit_control_high fields
  localparam int CTU_H_UNIT_ENABLE  = 7;
  localparam int CTU_H_STOP_IN_IDLE = 5;
  localparam int CTU_H_DELAY_GEN    = 4;
  localparam int CTU_H_EDGE_GATE    = 3;
  localparam int CTU_H_EDGE_ORDER   = 2;
  localparam int CTU_H_SRC_GROUND   = 1;
  localparam logic [7:0] CTU_H_WMASK = 8'hbe; // bits 6 and 0 stay zero
  // edge_control_low fields
  localparam int CTU_L_SECOND_POL = 7;
  localparam int CTU_L_SECOND_SRC = 5; // low bit of a two-bit field
  localparam int CTU_L_FIRST_POL  = 4;
  localparam int CTU_L_FIRST_SRC  = 2;
  localparam int CTU_L_SECOND_FLG = 1;
  localparam int CTU_L_FIRST_FLG  = 0;
  // current_control fields
  localparam int CTU_I_TRIM  = 2;
  localparam int CTU_I_RANGE = 0;
  // edge source encodings
  localparam logic [1:0] CTU_SRC_PIN_ONE = 2'h3;
  localparam logic [1:0] CTU_SRC_PIN_TWO = 2'h2;
  localparam logic [1:0] CTU_SRC_CAP_ONE = 2'h1;
  localparam logic [1:0] CTU_SRC_CAP_TWO = 2'h0;
  // current range encodings
  localparam logic [1:0] CTU_RNG_OFF  = 2'h0;
  localparam logic [1:0] CTU_RNG_X1   = 2'h1;
  localparam logic [1:0] CTU_RNG_X10  = 2'h2;
  localparam logic [1:0] CTU_RNG_X100 = 2'h3;
  // interrupt status bits
  localparam int CTU_IRQ_FIRST  = 0;
  localparam int CTU_IRQ_SECOND = 1;
  localparam int CTU_IRQ_PULSE  = 2;
  localparam logic [7:0] CTU_IRQ_WMASK = 8'h07;
  localparam logic [7:0] CTU_RST_BYTE  = 8'h00;
  // bus response states, gray along idle -> ack
  typedef enum logic [1:0] {
    CTU_BUS_IDLE = 2'b00,
    CTU_BUS_ACK  = 2'b01
  } ctu_bus_t;
endpackage
`default_nettype wire

/* ctu_top.sv */
`default_nettype none
// What this block does
// R1: sleep always switches the current source off
// R2: stop_in_idle set switches source off in idle
// R3: reset clears every control register to zero
// R4: source_ground ties the source output to ground
// R5: unit_enable turns on the source gate, edge events and delay pulse
// R6: delay_gen_enable turns on delay pulse generation
// R7: edge_gate passes or blocks all edge events
// R8: ordered mode ignores second edge before first
// R9: polarity bit picks rising or falling edge
// R10: two-bit source select picks pin or trigger
// R11: two readable writable flags record edge events
// R12: six-bit signed trim passed to current source
// R13: two-bit range: off, base, ten, hundred
// R14: high bit 6 reads zero, bit 0 reserved
// R15: first flag alone set charges the circuit
// R16: delay pulse driven on its own output
// R17: selected edge sets matching flag, clock synchronous
// R18: source on: enabled, range on, exactly one flag
module ctu_top
  import ctu_pkg::*;
(
  input  wire logic        clk_i,            // system clock, 100 MHz
  input  wire logic        rst_i,            // synchronous reset, active high
  input  wire logic        wb_cyc_i,         // bus cycle
  input  wire logic        wb_stb_i,         // bus strobe
  input  wire logic        wb_we_i,          // write enable
  input  wire logic [13:0] wb_adr_i,         // byte address
  input  wire logic [3:0]  wb_sel_i,         // byte lanes
  input  wire logic [31:0] wb_dat_i,         // write data
  output logic      [31:0] wb_dat_o,         // read data
  output logic             wb_ack_o,         // bus acknowledge
  input  wire logic        sleep_i,          // device in any sleep mode
  input  wire logic        idle_i,           // device in idle mode
  input  wire logic        edge_pin_one_i,   // external edge pin one
  input  wire logic        edge_pin_two_i,   // external edge pin two
  input  wire logic        capture_unit_one_trigger_i, // special event trigger one
  input  wire logic        capture_unit_two_trigger_i, // special event trigger two
  input  wire logic        compare_trip_i,   // comparator trip from pulse capacitor
  output logic             source_on_o,      // current source gate
  output logic             source_ground_o,  // source output grounded
  output logic [1:0]       current_range_o,  // current range to analog
  output logic [5:0]       current_trim_o,   // signed trim to analog
  output logic             delay_pulse_out_o,// delay pulse pin
  output logic             irq_o             // level interrupt
);
  import ctu_pkg::*;

  typedef struct packed {
    logic [7:0]  cur;       // current_control
    logic [7:0]  low;       // edge_control_low
    logic [7:0]  high;      // unit_control_high
    logic [7:0]  irq_stat;
    logic [7:0]  irq_mask;
    logic [3:0]  src_prev;  // previous level of the four sources
    logic        trip_prev;
    ctu_bus_t    bus;
    logic [31:0] rdata;
    logic        ack;
    logic        src_on;
    logic        gnd;
    logic [1:0]  rng;
    logic [5:0]  trim;
    logic        pulse;
    logic        irq;
  } ctu_state_t;

  ctu_state_t st_reg;
  ctu_state_t st_next;

  logic [3:0] srcs;
  logic       req;
  logic       wr_lane;
  logic       rise1;
  logic       fall1;
  logic       rise2;
  logic       fall2;
  logic       ev1;
  logic       ev2;
  logic       run;
  logic       one_flag;
  logic [7:0] wbyte;

  // source vector indexed by the select code
  assign srcs = {edge_pin_one_i, edge_pin_two_i,
                 capture_unit_one_trigger_i, capture_unit_two_trigger_i}; // [R10]

  // bus request decode, lane zero carries the byte
  assign req     = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign wr_lane = req & wb_we_i & wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  // edge detection on the selected sources
  always_comb begin
    logic [1:0] s1;
    logic [1:0] s2;
    s1 = st_reg.low[CTU_L_FIRST_SRC +: 2];
    s2 = st_reg.low[CTU_L_SECOND_SRC +: 2];
    rise1 = srcs[s1] & ~st_reg.src_prev[s1];                  // [R10]
    fall1 = ~srcs[s1] & st_reg.src_prev[s1];
    rise2 = srcs[s2] & ~st_reg.src_prev[s2];
    fall2 = ~srcs[s2] & st_reg.src_prev[s2];
  end

  // gated, polarity-selected and ordered edge events
  assign run = st_reg.high[CTU_H_UNIT_ENABLE] & st_reg.high[CTU_H_EDGE_GATE]; // [R5] [R7]
  assign ev1 = run & (st_reg.low[CTU_L_FIRST_POL] ? rise1 : fall1);          // [R9] [R17]
  assign ev2 = run & (st_reg.low[CTU_L_SECOND_POL] ? rise2 : fall2)          // [R9] [R17]
             & (~st_reg.high[CTU_H_EDGE_ORDER] | st_reg.low[CTU_L_FIRST_FLG]); // [R8]
  assign one_flag = st_reg.low[CTU_L_FIRST_FLG] ^ st_reg.low[CTU_L_SECOND_FLG];

  // next-state logic for registers, flags, outputs and bus
  always_comb begin
    st_next          = st_reg;
    st_next.src_prev = srcs;
    st_next.trip_prev = compare_trip_i;
    st_next.ack      = 1'b0;
    st_next.bus      = CTU_BUS_IDLE;
    // register writes
    if (wr_lane) begin
      case (wb_adr_i)
        CTU_ADR_CURRENT:    st_next.cur  = wbyte;                       // [R12] [R13]
        CTU_ADR_EDGE_LOW:   st_next.low  = wbyte;                       // [R11] [R15]
        CTU_ADR_UNIT_HIGH:  st_next.high = wbyte & CTU_H_WMASK;         // [R14]
        CTU_ADR_IRQ_STATUS: st_next.irq_stat = st_reg.irq_stat & ~(wbyte & CTU_IRQ_WMASK);
        CTU_ADR_IRQ_MASK:   st_next.irq_mask = wbyte & CTU_IRQ_WMASK;
        default: ;
      endcase
    end
    // hardware edge events win over a software write in the same cycle
    if (ev1) begin
      st_next.low[CTU_L_FIRST_FLG]  = 1'b1;                             // [R17] [R11]
      st_next.irq_stat[CTU_IRQ_FIRST] = 1'b1;
    end
    if (ev2) begin
      st_next.low[CTU_L_SECOND_FLG] = 1'b1;                             // [R17] [R11]
      st_next.irq_stat[CTU_IRQ_SECOND] = 1'b1;
    end
    // analog controls
    st_next.src_on = st_reg.high[CTU_H_UNIT_ENABLE]                     // [R5] [R18]
                   & (st_reg.cur[CTU_I_RANGE +: 2] != CTU_RNG_OFF)      // [R13]
                   & one_flag                                           // [R15] [R18]
                   & ~sleep_i                                           // [R1]
                   & ~(idle_i & st_reg.high[CTU_H_STOP_IN_IDLE]);       // [R2]
    st_next.gnd  = st_reg.high[CTU_H_SRC_GROUND];                       // [R4]
    st_next.rng  = st_reg.cur[CTU_I_RANGE +: 2];                        // [R13]
    st_next.trim = st_reg.cur[CTU_I_TRIM +: 6];                         // [R12]
    // delay pulse: high from first edge until the comparator trips
    st_next.pulse = st_reg.high[CTU_H_UNIT_ENABLE] & st_reg.high[CTU_H_DELAY_GEN] // [R6]
                  & st_reg.low[CTU_L_FIRST_FLG] & ~compare_trip_i;      // [R16]
    // pulse end is judged only once the new pulse level is known
    if (st_reg.pulse & ~st_next.pulse) st_next.irq_stat[CTU_IRQ_PULSE] = 1'b1;
    st_next.irq  = |(st_next.irq_stat & st_next.irq_mask);
    // read data and acknowledge
    if (req) begin
      st_next.ack   = 1'b1;
      st_next.bus   = CTU_BUS_ACK;
      st_next.rdata = '0;
      if (!wb_we_i) begin
        case (wb_adr_i)
          CTU_ADR_CURRENT:    st_next.rdata[7:0] = st_reg.cur;
          CTU_ADR_EDGE_LOW:   st_next.rdata[7:0] = st_reg.low;
          CTU_ADR_UNIT_HIGH:  st_next.rdata[7:0] = st_reg.high & CTU_H_WMASK; // [R14]
          CTU_ADR_IRQ_STATUS: st_next.rdata[7:0] = st_reg.irq_stat;
          CTU_ADR_IRQ_MASK:   st_next.rdata[7:0] = st_reg.irq_mask;
          default:            st_next.rdata[7:0] = CTU_RST_BYTE;
        endcase
      end
    end
  end

  // state register, everything cleared on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;                                                     // [R3]
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o          = st_reg.rdata;
  assign wb_ack_o          = st_reg.ack;
  assign source_on_o       = st_reg.src_on;
  assign source_ground_o   = st_reg.gnd;
  assign current_range_o   = st_reg.rng;
  assign current_trim_o    = st_reg.trim;
  assign delay_pulse_out_o = st_reg.pulse;
  assign irq_o             = st_reg.irq;

  // checks
  // every output is a flip-flop, so most properties look one edge after
  // the cause; that keeps each expectation in step with the real latency
  // of the analog controls, the pulse pin and the bus answer
  // all of them are switched off while reset is applied, except the one
  // that looks at what reset itself leaves behind in the registers
  // the analog side cannot be seen here: the checks stop at the gate,
  // ground, range and trim lines that leave the block
  // edge checks name the raw event terms so a lost flag shows at once

  // power modes
  // sleep forces the source off on the next edge
  a_sleep_off: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    sleep_i
    |=> !source_on_o)
    else $error("source on after sleep");

  // idle with stop_in_idle set forces the source off
  a_idle_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (idle_i && st_reg.high[CTU_H_STOP_IN_IDLE])
    |=> !source_on_o)
    else $error("source on in idle with stop set");

  // a charging setup keeps charging, in idle too while stop is clear
  a_charge_on: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    (one_flag && st_reg.low[CTU_L_FIRST_FLG] && st_reg.high[CTU_H_UNIT_ENABLE]
     && st_reg.cur[CTU_I_RANGE +: 2] != CTU_RNG_OFF && !sleep_i
     && !(idle_i && st_reg.high[CTU_H_STOP_IN_IDLE])) |=> source_on_o)
    else $error("source not charging");

  // reset and controls
  // reset leaves every control register at zero
  a_reset_clear: assert property (@(posedge clk_i) // [R3]
    rst_i
    |=> (st_reg.high == 8'h00 && st_reg.low == 8'h00 && st_reg.cur == 8'h00))
    else $error("registers not cleared by reset");

  // ground output follows its control one edge late
  a_ground_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    1'b1
    |-> source_ground_o == $past(st_reg.high[CTU_H_SRC_GROUND]))
    else $error("ground output wrong");

  // ground released when its control is clear
  a_ground_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    !st_reg.high[CTU_H_SRC_GROUND]
    |=> !source_ground_o)
    else $error("ground held without control");

  // a disabled unit neither charges nor pulses
  a_disabled_off: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    !st_reg.high[CTU_H_UNIT_ENABLE]
    |=> !source_on_o && !delay_pulse_out_o)
    else $error("disabled unit active");

  // range output is a copy of the range field
  a_range_copy: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    1'b1
    |-> current_range_o == $past(st_reg.cur[CTU_I_RANGE +: 2]))
    else $error("range output wrong");

  // range off keeps the source off
  a_range_off: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    st_reg.cur[CTU_I_RANGE +: 2] == CTU_RNG_OFF
    |=> !source_on_o)
    else $error("source on with range off");

  // trim output is a copy of the signed trim field
  a_trim_copy: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    1'b1
    |-> current_trim_o == $past(st_reg.cur[CTU_I_TRIM +: 6]))
    else $error("trim output wrong");

  // unimplemented and reserved high bits never hold a one
  a_high_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    1'b1
    |-> (st_reg.high & ~CTU_H_WMASK) == 8'h00)
    else $error("unimplemented bit set");

  // source on only with enable, range and exactly one flag
  a_source_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    source_on_o
    |-> $past(one_flag && st_reg.high[CTU_H_UNIT_ENABLE]
       && st_reg.cur[CTU_I_RANGE +: 2] != CTU_RNG_OFF))
    else $error("source on wrongly");

  // both flags set stops the charge
  a_both_flags: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (st_reg.low[CTU_L_FIRST_FLG] && st_reg.low[CTU_L_SECOND_FLG])
    |=> !source_on_o)
    else $error("source on with both flags");

  // edge logic
  // blocked edges leave both flags alone
  a_gate_block: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (!st_reg.high[CTU_H_EDGE_GATE] && !wr_lane)
    |=> $stable(st_reg.low[CTU_L_SECOND_FLG:CTU_L_FIRST_FLG]))
    else $error("flag set while edges blocked");

  // ordered mode holds the second flag until the first is set
  a_order_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (st_reg.high[CTU_H_EDGE_ORDER] && !st_reg.low[CTU_L_FIRST_FLG] && !wr_lane)
    |=> !$rose(st_reg.low[CTU_L_SECOND_FLG]))
    else $error("second edge taken before first");

  // a first-edge event lands in its flag
  a_edge_set: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    ev1
    |=> st_reg.low[CTU_L_FIRST_FLG])
    else $error("first edge lost");

  // a second-edge event lands in its flag
  a_second_set: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    ev2
    |=> st_reg.low[CTU_L_SECOND_FLG])
    else $error("second edge lost");

  // rising polarity ignores a falling first source
  a_first_polarity: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (st_reg.low[CTU_L_FIRST_POL] && fall1 && !st_reg.low[CTU_L_FIRST_FLG] && !wr_lane)
    |=> !st_reg.low[CTU_L_FIRST_FLG])
    else $error("first edge wrong polarity");

  // rising polarity ignores a falling second source
  a_second_polarity: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (st_reg.low[CTU_L_SECOND_POL] && fall2 && !st_reg.low[CTU_L_SECOND_FLG] && !wr_lane)
    |=> !st_reg.low[CTU_L_SECOND_FLG])
    else $error("second edge wrong polarity");

  // a set first flag stays set until software writes the register
  a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (st_reg.low[CTU_L_FIRST_FLG] && !wr_lane)
    |=> st_reg.low[CTU_L_FIRST_FLG])
    else $error("first flag lost");

  // delay pulse
  // no pulse without delay generation
  a_delay_gen: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    !st_reg.high[CTU_H_DELAY_GEN]
    |=> !delay_pulse_out_o)
    else $error("pulse without delay generation");

  // pulse rises after the first flag while the comparator is low
  a_pulse_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    (st_reg.high[CTU_H_UNIT_ENABLE] && st_reg.high[CTU_H_DELAY_GEN]
     && st_reg.low[CTU_L_FIRST_FLG] && !compare_trip_i)
    |=> delay_pulse_out_o)
    else $error("pulse missing");

  // comparator trip ends the pulse
  a_pulse_trip: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    compare_trip_i
    |=> !delay_pulse_out_o)
    else $error("pulse past trip");

  // pulse end is recorded as an interrupt event
  a_pulse_irq: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    $fell(delay_pulse_out_o)
    |-> st_reg.irq_stat[CTU_IRQ_PULSE])
    else $error("pulse end not recorded");

  // bus and interrupt
  // every taken request is answered once, one edge later
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    req
    |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");

  // acknowledge never stands two cycles
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o
    |=> !wb_ack_o)
    else $error("ack held too long");

  // registers are a byte wide, upper read lanes stay zero
  a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o
    |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data set");

  // interrupt line is high exactly while an unmasked bit is set
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> irq_o == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("interrupt level wrong");
endmodule // ctu_top
`default_nettype wire

/* ctu_edge_model.sv */
`default_nettype none
// far-side model: two edge pins and two capture triggers, levels held by command
module ctu_edge_model (
  input  wire logic       clk_i,       // system clock
  input  wire logic       rst_i,       // synchronous reset
  input  wire logic       set_i,       // load one line this cycle
  input  wire logic [1:0] which_i,     // line index, same code as source select
  input  wire logic       level_i,     // new level for that line
  output logic            pin_one_o,   // external edge pin one
  output logic            pin_two_o,   // external edge pin two
  output logic            cap_one_o,   // trigger one
  output logic            cap_two_o    // trigger two
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lines_reg;
  // each line changes only after a clock edge, so the unit sees clean transitions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lines_reg <= 4'h0;
    end else if (set_i) begin
      lines_reg[which_i] <= level_i;
    end
  end
  // index order follows the source encoding: 3 pin one, 2 pin two, 1 trig one, 0 trig two
  assign pin_one_o = lines_reg[3];
  assign pin_two_o = lines_reg[2];
  assign cap_one_o = lines_reg[1];
  assign cap_two_o = lines_reg[0];
endmodule // ctu_edge_model
`default_nettype wire

/* ctu_top_tb_top.sv */
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ctu_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ctu_pkg::*;
  logic clk_i = 1'b0, rst_i, cyc, stb, we, sleep_i, idle_i, trip, set_e, lvl_e;
  logic [13:0] adr;
  logic [31:0] dat_w, dat_r;
  logic [1:0]  which_e, rng;
  logic [5:0]  trim;
  logic        ack, p1, p2, c1, c2, src_on, gnd, pulse, irq;
  logic [7:0]  q;
  int          err_total = 0;
  int          tests_run = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  ctu_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .sleep_i(sleep_i), .idle_i(idle_i), .edge_pin_one_i(p1), .edge_pin_two_i(p2),
    .capture_unit_one_trigger_i(c1), .capture_unit_two_trigger_i(c2),
    .compare_trip_i(trip), .source_on_o(src_on), .source_ground_o(gnd),
    .current_range_o(rng), .current_trim_o(trim), .delay_pulse_out_o(pulse), .irq_o(irq));
  ctu_edge_model u_far (.clk_i(clk_i), .rst_i(rst_i), .set_i(set_e), .which_i(which_e),
    .level_i(lvl_e), .pin_one_o(p1), .pin_two_o(p2), .cap_one_o(c1), .cap_two_o(c2));
  // one classic bus cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [13:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) err_total++;
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [13:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  // let registered outputs catch up with a new configuration
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask
  // drive one far-side line to a level, then wait for the flag to land
  task automatic edge_set(input logic [1:0] w, input logic l);
    @(posedge clk_i);
    set_e <= 1'b1;
    which_e <= w;
    lvl_e <= l;
    @(posedge clk_i);
    set_e <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic final_report();
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    {rst_i, cyc, stb, we, sleep_i, idle_i, trip, set_e, lvl_e} <= 9'h100;
    {adr, dat_w, which_e} <= '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTU_ADR_CURRENT);
    `CHK(q, 8'h00)
    rd(CTU_ADR_EDGE_LOW);
    `CHK(q, 8'h00)
    rd(CTU_ADR_UNIT_HIGH);
    `CHK(q, 8'h00)
    `CHK({src_on, gnd, pulse, irq}, 4'h0)
    wr(CTU_ADR_UNIT_HIGH, 8'hff);
    rd(CTU_ADR_UNIT_HIGH);
    `CHK(q, 8'hbe)
    rd(14'h0100);
    `CHK(q, 8'h00)
    // every range, trim stepping from 6'h1f by two
    for (int r = 0; r < 4; r++) begin
      wr(CTU_ADR_CURRENT, {6'h1f + 6'(r * 2), r[1:0]});
      settle();
      `CHK(rng, r[1:0])
      `CHK(trim, 6'h1f + 6'(r * 2))
    end
    wr(CTU_ADR_UNIT_HIGH, 8'h80);
    wr(CTU_ADR_CURRENT, 8'h01);
    wr(CTU_ADR_EDGE_LOW, 8'h01);
    settle();
    `CHK(src_on, 1'b1)
    sleep_i <= 1'b1;
    settle();
    `CHK(src_on, 1'b0)
    sleep_i <= 1'b0;
    idle_i <= 1'b1;
    settle();
    `CHK(src_on, 1'b1)
    wr(CTU_ADR_UNIT_HIGH, 8'ha0);
    settle();
    `CHK(src_on, 1'b0)
    idle_i <= 1'b0;
    wr(CTU_ADR_EDGE_LOW, 8'h03);
    settle();
    `CHK(src_on, 1'b0)
    wr(CTU_ADR_EDGE_LOW, 8'h01);
    wr(CTU_ADR_CURRENT, 8'h00);
    settle();
    `CHK(src_on, 1'b0)
    wr(CTU_ADR_CURRENT, 8'h01);
    wr(CTU_ADR_UNIT_HIGH, 8'h02);
    settle();
    `CHK({src_on, gnd}, 2'b01)
    wr(CTU_ADR_UNIT_HIGH, 8'h90);
    settle();
    `CHK({gnd, pulse}, 2'b01)
    trip <= 1'b1;
    settle();
    `CHK(pulse, 1'b0)
    rd(CTU_ADR_IRQ_STATUS);
    `CHK(q[2], 1'b1)
    trip <= 1'b0;
    // every source, rising polarity, edges passed
    wr(CTU_ADR_UNIT_HIGH, 8'h88);
    for (int s = 0; s < 4; s++) begin
      wr(CTU_ADR_EDGE_LOW, {3'h0, 1'b1, s[1:0], 2'h0});
      edge_set(s[1:0], 1'b1);
      rd(CTU_ADR_EDGE_LOW);
      `CHK(q[0], 1'b1)
      edge_set(s[1:0], 1'b0);
    end
    wr(CTU_ADR_EDGE_LOW, 8'h0c);
    edge_set(2'h3, 1'b1);
    rd(CTU_ADR_EDGE_LOW);
    `CHK(q[0], 1'b0)
    edge_set(2'h3, 1'b0);
    rd(CTU_ADR_EDGE_LOW);
    `CHK(q[0], 1'b1)
    wr(CTU_ADR_UNIT_HIGH, 8'h8c);
    wr(CTU_ADR_EDGE_LOW, 8'hc0);
    edge_set(2'h2, 1'b1);
    rd(CTU_ADR_EDGE_LOW);
    `CHK(q[1], 1'b0)
    edge_set(2'h2, 1'b0);
    wr(CTU_ADR_UNIT_HIGH, 8'h88);
    edge_set(2'h2, 1'b1);
    rd(CTU_ADR_EDGE_LOW);
    `CHK(q[1], 1'b1)
    wr(CTU_ADR_UNIT_HIGH, 8'h80);
    wr(CTU_ADR_EDGE_LOW, 8'h1c);
    edge_set(2'h3, 1'b1);
    rd(CTU_ADR_EDGE_LOW);
    `CHK(q[0], 1'b0)
    edge_set(2'h3, 1'b0);
    // interrupt raised, masked, cleared
    wr(CTU_ADR_UNIT_HIGH, 8'h88);
    wr(CTU_ADR_IRQ_STATUS, 8'h07);
    wr(CTU_ADR_IRQ_MASK, 8'h01);
    edge_set(2'h3, 1'b1);
    `CHK(irq, 1'b1)
    wr(CTU_ADR_IRQ_MASK, 8'h00);
    settle();
    `CHK(irq, 1'b0)
    wr(CTU_ADR_IRQ_MASK, 8'h01);
    settle();
    `CHK(irq, 1'b1)
    wr(CTU_ADR_IRQ_STATUS, 8'h01);
    settle();
    `CHK(irq, 1'b0)
    rd(CTU_ADR_IRQ_STATUS);
    `CHK(q[0], 1'b0)
    final_report();
  end
endmodule // ctu_top_tb_top
`default_nettype wire
